// file: verilog/i2c_addressing_gencall_irq.sv
// Top of the two-wire addressing, broadcast and interrupt block
//
// Summary of operation
// - Slave holds clock low between bytes
// - Prefix 11110 marks a 10-bit address
// - Decode broadcast, reserved and 10-bit codes
// - Length select picks 7 or 10-bit match
// - 10-bit write: two address bytes, then data
// - 10-bit read: restart, first byte, direction one
// - Accept broadcast data until disabled or ended
// - Broadcast sets addressed-as-slave flag too
// - Address byte readable; 00 means broadcast
// - First broadcast data byte passed raw
// - Wait mode may gate and abort transfers
// - Stop mode freezes block, keeps registers
// - One interrupt from three status flags
// - Enable gates interrupt; write one clears
// - Reset returns control to defaults
// - Broadcast enable gates broadcast handling
// - Three upper bits hold 10-bit address top
// - Done flag set per byte, cleared by access
`timescale 1ns/100ps
`default_nettype none
module i2c_addressing_gencall_irq (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl_clk,
  input wire logic i_scl_rst_n,
  input wire logic i_sda,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_iface_enable,
  input wire logic i_irq_enable,
  input wire logic i_addr_len_sel,
  input wire logic i_broadcast_accept_en,
  input wire logic [6:0] i_own_addr_reg,
  input wire logic [2:0] i_own_addr_upper,
  input wire logic i_tx_mode,
  input wire logic i_wait_mode,
  input wire logic i_wait_gate_cfg,
  input wire logic i_stop_mode,
  input wire logic i_arb_lost_event,
  input wire logic i_data_read,
  input wire logic i_data_write,
  input wire logic i_ctrl_write,
  input wire logic i_irq_clear,
  output logic [7:0] o_xfer_data_reg,
  output logic o_xfer_done_flag,
  output logic o_addressed_as_slave_flag,
  output logic o_arb_lost_flag,
  output logic o_irq_pending_flag,
  output logic o_broadcast_match,
  output logic o_irq,
  output logic o_scl_hold_oe,
  output logic o_sda_ack_oe
);
  // ==========================================================
  // Activity gating
  logic active_sys;
  logic link_active;
  logic [9:0] own_addr;
  always_comb begin
    active_sys = i_iface_enable && !i_stop_mode && !(i_wait_mode && i_wait_gate_cfg);
  end
  // Own address: lower seven bits plus upper field in 10-bit mode
  assign own_addr = i_addr_len_sel ? {i_own_addr_upper, i_own_addr_reg} :
                                     {3'h0, i_own_addr_reg};

  // ==========================================================
  // Crossings into the link domain
  typedef struct packed {
    logic [1:0] act;
    logic [1:0] len;
    logic [1:0] gce;
  } lsync_t;
  lsync_t ls, next_ls;
  always_comb begin
    next_ls = ls;
    next_ls.act = {ls.act[0], active_sys};
    next_ls.len = {ls.len[0], i_addr_len_sel};
    next_ls.gce = {ls.gce[0], i_broadcast_accept_en};
  end
  always_ff @(posedge i_scl_clk or negedge i_scl_rst_n) begin
    if (!i_scl_rst_n) begin
      ls <= '0;
    end else begin
      ls <= next_ls;
    end
  end
  assign link_active = ls.act[1];

  i2c_evt_if evt ();
  logic link_ack;
  i2c_link_rx u_rx (
    .i_scl_clk(i_scl_clk),
    .i_rst_n(i_scl_rst_n),
    .i_sda(i_sda),
    .i_start(i_start),
    .i_stop(i_stop),
    .i_active(link_active),
    .i_addr_len_sel(ls.len[1]),
    .i_broadcast_accept_en(ls.gce[1]),
    .i_own_addr(own_addr),
    .o_ack(link_ack),
    .evt(evt)
  );
  // Own address is quasi-static: configured before the interface is enabled

  // ==========================================================
  // System-domain state
  typedef struct packed {
    logic [2:0] tog_sync;
    logic [7:0] data;
    logic done;
    logic aas;
    logic arb;
    logic pend;
    logic bmatch;
    logic irq;
  } sstate_t;
  sstate_t s, next_s;
  logic byte_evt;
  logic hold;
  logic flag_rise;
  always_comb begin
    next_s = s;
    next_s.tog_sync = {s.tog_sync[1:0], evt.toggle};
    byte_evt = s.tog_sync[2] ^ s.tog_sync[1];
    flag_rise = 1'b0;
    // In stop mode only the toggle sync moves: registers keep their contents
    if (!i_stop_mode) begin
      if ((i_data_read && !i_tx_mode) || (i_data_write && i_tx_mode)) begin
        next_s.done = 1'b0;
      end
      if (i_ctrl_write) begin
        next_s.aas = 1'b0;
      end
      if (i_irq_clear) begin
        next_s.pend = 1'b0;
      end
      if (i_arb_lost_event) begin
        next_s.arb = 1'b1;
        flag_rise = 1'b1;
      end
      if (byte_evt && active_sys) begin
        next_s.data = evt.data;
        next_s.done = 1'b1;
        flag_rise = 1'b1;
        if (evt.is_addr) begin
          next_s.aas = 1'b1;
          next_s.bmatch = evt.is_gen_call && evt.data == i2c_addr_pkg::GEN_CALL_DATA;
        end
      end
      if (flag_rise) begin
        next_s.pend = 1'b1;
      end
      next_s.irq = i_irq_enable && next_s.pend;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{data: i2c_addr_pkg::DATA_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Clock stretching between bytes
  logic hold_q;
  i2c_stretch u_stretch (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_byte_done(byte_evt && active_sys),
    .i_release(i_data_read || i_data_write),
    .i_active(active_sys),
    .o_hold(hold)
  );
  // Registered so the open-drain enable comes straight from a flip-flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold;
    end
  end

  assign o_xfer_data_reg = s.data;
  assign o_xfer_done_flag = s.done;
  assign o_addressed_as_slave_flag = s.aas;
  assign o_arb_lost_flag = s.arb;
  assign o_irq_pending_flag = s.pend;
  assign o_broadcast_match = s.bmatch;
  assign o_irq = s.irq;
  assign o_scl_hold_oe = hold_q;
  // Ack lasts one bus clock, too short to cross: driven from the link flop
  assign o_sda_ack_oe = link_ack;
endmodule
`default_nettype wire

// file: verilog/i2c_addr_pkg.sv
// Shared constants and types for the two-wire addressing and event block
package i2c_addr_pkg;
  // ==========================================================
  // First-byte address codes
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [6:0] RSV_BUS_FORMAT = 7'h02;
  localparam logic [6:0] RSV_FUTURE = 7'h03;
  localparam logic [4:0] RSV_HIGH_PREFIX = 5'h1F;
  localparam logic [7:0] GEN_CALL_DATA = 8'h00;
  // ==========================================================
  // Field positions and reset values
  localparam int FIRST_PREFIX_MSB = 7;
  localparam int FIRST_PREFIX_LSB = 3;
  localparam int FIRST_UPPER_MSB = 2;
  localparam int FIRST_UPPER_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h8;
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  // ==========================================================
  // Link-side byte decoder states
  typedef enum logic [4:0] {
    L_IDLE = 5'b00001,
    L_ADDR1 = 5'b00010,
    L_ADDR2 = 5'b00100,
    L_DATA = 5'b01000,
    L_IGNORE = 5'b10000
  } link_state_t;
endpackage

// file: verilog/i2c_evt_if.sv
// Interface carrying byte events from the link domain to the system domain
`timescale 1ns/100ps
`default_nettype none
interface i2c_evt_if;
  logic toggle;
  logic [7:0] data;
  logic is_addr;
  logic is_gen_call;
  modport src (output toggle, output data, output is_addr, output is_gen_call);
  modport dst (input toggle, input data, input is_addr, input is_gen_call);
endinterface
`default_nettype wire

// file: verilog/i2c_link_rx.sv
// Link-domain bit shifter and first-byte address decoder
`timescale 1ns/100ps
`default_nettype none
module i2c_link_rx (
  input wire logic i_scl_clk,
  input wire logic i_rst_n,
  input wire logic i_sda,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_active,
  input wire logic i_addr_len_sel,
  input wire logic i_broadcast_accept_en,
  input wire logic [9:0] i_own_addr,
  output logic o_ack,
  i2c_evt_if.src evt
);
  typedef struct packed {
    i2c_addr_pkg::link_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic tog;
    logic [7:0] data;
    logic is_addr;
    logic gc;
    logic ten_hit;
  } lstate_t;
  lstate_t s, next_s;
  logic [7:0] byte_in;
  logic [6:0] a7;
  always_comb begin
    next_s = s;
    byte_in = {s.sh[6:0], i_sda};
    a7 = byte_in[7:1];
    next_s.ack = 1'b0;
    if (s.cnt == i2c_addr_pkg::BIT_COUNT_LAST) begin
      next_s.cnt = i2c_addr_pkg::BIT_COUNT_RESET;
    end else begin
      next_s.cnt = s.cnt + 4'h1;
      next_s.sh = byte_in;
    end
    if (s.cnt == i2c_addr_pkg::BIT_COUNT_LAST - 4'h1 && !i_active) begin
      // Checked at the byte end: the bus clock stands still between frames,
      // so the activity sync is only current once a byte has clocked it
      next_s.st = i2c_addr_pkg::L_IDLE;
      next_s.gc = 1'b0;
      next_s.ten_hit = 1'b0;
    end else if (s.cnt == i2c_addr_pkg::BIT_COUNT_LAST - 4'h1) begin
      unique case (s.st)
        i2c_addr_pkg::L_ADDR1: begin
          if (a7 == i2c_addr_pkg::GEN_CALL_ADDR && !byte_in[i2c_addr_pkg::DIR_BIT]) begin
            if (i_broadcast_accept_en) begin
              next_s.ack = 1'b1;
              next_s.gc = 1'b1;
              next_s.st = i2c_addr_pkg::L_DATA;
              next_s.tog = ~s.tog;
              next_s.data = byte_in;
              next_s.is_addr = 1'b1;
            end else begin
              next_s.st = i2c_addr_pkg::L_IGNORE;
            end
          end else if (a7 == i2c_addr_pkg::RSV_BUS_FORMAT || a7 == i2c_addr_pkg::RSV_FUTURE ||
                       byte_in[7:3] == i2c_addr_pkg::RSV_HIGH_PREFIX) begin
            next_s.st = i2c_addr_pkg::L_IGNORE;
          end else if (byte_in[7:3] == i2c_addr_pkg::TEN_BIT_PREFIX) begin
            if (i_addr_len_sel && byte_in[2:1] == i_own_addr[9:8]) begin
              if (byte_in[i2c_addr_pkg::DIR_BIT] && s.ten_hit) begin
                next_s.ack = 1'b1;
                next_s.st = i2c_addr_pkg::L_DATA;
                next_s.tog = ~s.tog;
                next_s.data = byte_in;
                next_s.is_addr = 1'b1;
              end else if (!byte_in[i2c_addr_pkg::DIR_BIT]) begin
                next_s.ack = 1'b1;
                next_s.st = i2c_addr_pkg::L_ADDR2;
              end else begin
                next_s.st = i2c_addr_pkg::L_IGNORE;
              end
            end else begin
              next_s.st = i2c_addr_pkg::L_IGNORE;
            end
          end else if (!i_addr_len_sel && a7 == i_own_addr[6:0]) begin
            next_s.ack = 1'b1;
            next_s.st = i2c_addr_pkg::L_DATA;
            next_s.tog = ~s.tog;
            next_s.data = byte_in;
            next_s.is_addr = 1'b1;
          end else begin
            next_s.st = i2c_addr_pkg::L_IGNORE;
          end
        end
        i2c_addr_pkg::L_ADDR2: begin
          if (byte_in == i_own_addr[7:0]) begin
            next_s.ack = 1'b1;
            next_s.ten_hit = 1'b1;
            next_s.st = i2c_addr_pkg::L_DATA;
            next_s.tog = ~s.tog;
            next_s.data = byte_in;
            next_s.is_addr = 1'b1;
          end else begin
            next_s.st = i2c_addr_pkg::L_IGNORE;
          end
        end
        i2c_addr_pkg::L_DATA: begin
          // Data bytes, the first one after a broadcast too, go up raw
          if (s.gc && !i_broadcast_accept_en) begin
            next_s.st = i2c_addr_pkg::L_IGNORE;
          end else begin
            next_s.ack = 1'b1;
            next_s.tog = ~s.tog;
            next_s.data = byte_in;
            next_s.is_addr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (i_start) begin
      // Repeated start keeps the 10-bit hit so a read re-address can match
      next_s.st = i2c_addr_pkg::L_ADDR1;
      next_s.cnt = i2c_addr_pkg::BIT_COUNT_RESET;
      next_s.gc = 1'b0;
      next_s.ack = 1'b0;
    end
    if (i_stop) begin
      next_s.st = i2c_addr_pkg::L_IDLE;
      next_s.gc = 1'b0;
      next_s.ten_hit = 1'b0;
      next_s.ack = 1'b0;
    end
  end
  always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{st: i2c_addr_pkg::L_IDLE, cnt: i2c_addr_pkg::BIT_COUNT_RESET,
             sh: i2c_addr_pkg::DATA_RESET, data: i2c_addr_pkg::DATA_RESET, default: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign o_ack = s.ack;
  assign evt.toggle = s.tog;
  assign evt.data = s.data;
  assign evt.is_addr = s.is_addr;
  assign evt.is_gen_call = s.gc;
endmodule
`default_nettype wire

// file: verilog/i2c_stretch.sv
// System-domain clock-stretch hold that keeps the bus clock low
`timescale 1ns/100ps
`default_nettype none
module i2c_stretch (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_byte_done,
  input wire logic i_release,
  input wire logic i_active,
  output logic o_hold
);
  typedef struct packed {
    logic hold;
  } hstate_t;
  hstate_t s, next_s;
  always_comb begin
    next_s = s;
    // A fresh byte wins over a simultaneous release
    if (i_release) begin
      next_s.hold = 1'b0;
    end
    if (i_byte_done) begin
      next_s.hold = 1'b1;
    end
    if (!i_active) begin
      next_s.hold = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{hold: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign o_hold = s.hold;
endmodule
`default_nettype wire

// file: sim/i2c_addressing_gencall_irq_properties.sv
// Checker for the addressing, broadcast and interrupt block, bound to its top
`timescale 1ns/100ps
`default_nettype none
module i2c_addressing_gencall_irq_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_irq_enable,
  input wire logic i_broadcast_accept_en,
  input wire logic i_tx_mode,
  input wire logic i_stop_mode,
  input wire logic i_arb_lost_event,
  input wire logic i_data_read,
  input wire logic i_ctrl_write,
  input wire logic i_irq_clear,
  input wire logic [7:0] o_xfer_data_reg,
  input wire logic o_xfer_done_flag,
  input wire logic o_addressed_as_slave_flag,
  input wire logic o_arb_lost_flag,
  input wire logic o_irq_pending_flag,
  input wire logic o_broadcast_match,
  input wire logic o_irq,
  input wire logic o_scl_hold_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Interrupt
  a_irq_level: assert property ((i_irq_enable && o_irq_pending_flag && !i_irq_clear &&
    !i_stop_mode) |=> o_irq)
    else $error("irq missing while enabled and pending");
  a_irq_gated: assert property ((o_irq && !$past(i_stop_mode)) |->
    $past(i_irq_enable) && o_irq_pending_flag)
    else $error("irq raised without enable and pending");
  a_irq_sources: assert property ($rose(o_irq_pending_flag) |-> ##[0:1]
    (o_arb_lost_flag || o_xfer_done_flag || o_addressed_as_slave_flag))
    else $error("pending set with no source flag");
  a_arb_sets: assert property ((i_arb_lost_event && !i_stop_mode) |=> ##[0:3] o_arb_lost_flag)
    else $error("arbitration flag not set");
  // ==========================================================
  // Flags and modes
  a_stop_frozen: assert property ((i_stop_mode && $past(i_stop_mode)) |-> $stable({
    o_xfer_data_reg, o_xfer_done_flag, o_addressed_as_slave_flag, o_arb_lost_flag,
    o_irq_pending_flag}))
    else $error("state changed in stop mode");
  a_aas_clear: assert property ((i_ctrl_write && !i_stop_mode) |=>
    !o_addressed_as_slave_flag)
    else $error("addressed flag not cleared by control write");
  a_done_clear: assert property ((i_data_read && !i_tx_mode && !i_stop_mode) |=>
    !o_xfer_done_flag)
    else $error("done flag not cleared by receive read");
  a_bcast_data: assert property ($rose(o_broadcast_match) |->
    o_xfer_data_reg == 8'h00 && i_broadcast_accept_en)
    else $error("broadcast match without zero byte or enable");
  a_hold_done: assert property ($rose(o_scl_hold_oe) |-> ##[0:2] o_xfer_done_flag)
    else $error("clock held low without a finished byte");
endmodule
bind i2c_addressing_gencall_irq i2c_addressing_gencall_irq_properties props (.*);
`default_nettype wire

// file: sim/i2c_bus_master_model.sv
// Behavioural bus master that clocks bytes into the block's link side
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_master_model (
  input wire logic i_hold,
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda,
  output logic o_start,
  output logic o_stop
);
  bit stuck = 0;
  bit acked = 0;
  initial begin
    o_scl = 0;
    o_sda = 1;
    o_start = 0;
    o_stop = 0;
  end
  // Clock stands low between frames
  task automatic tick();
    #3 o_scl = 1;
    #3 o_scl = 0;
  endtask
  task automatic send(input bit s, input logic [7:0] b);
    int n;
    n = 0;
    while (i_hold && n < 200) begin
      #50;
      n++;
    end
    if (n == 200) stuck = 1;
    o_start = s;
    if (s) tick();
    o_start = 0;
    for (int i = 7; i >= 0; i--) begin
      o_sda = b[i];
      tick();
    end
    // Released for the ack; pull-up gives 1 unless the slave pulls low
    o_sda = 1;
    #3 acked = !i_sda_line;
    o_scl = 1;
    #3 o_scl = 0;
  endtask
  task automatic stop();
    o_stop = 1;
    tick();
    o_stop = 0;
  endtask
endmodule
`default_nettype wire

// file: sim/i2c_addressing_gencall_irq_test.sv
// Testbench for the addressing, broadcast and interrupt block
`timescale 1ns/100ps
`default_nettype none
module i2c_addressing_gencall_irq_test;
  logic i_clk = 0, i_rst_n = 0, i_iface_enable = 0, i_irq_enable = 0, i_addr_len_sel = 0;
  logic i_broadcast_accept_en = 0, i_tx_mode = 0, i_wait_mode = 0, i_wait_gate_cfg = 0;
  logic i_stop_mode = 0, i_arb_lost_event = 0, i_data_read = 0, i_data_write = 0;
  logic i_ctrl_write = 0, i_irq_clear = 0;
  logic [6:0] i_own_addr_reg = 7'h2A;
  logic [2:0] i_own_addr_upper = 3'h0;
  logic [7:0] o_xfer_data_reg;
  logic o_xfer_done_flag, o_addressed_as_slave_flag, o_arb_lost_flag, o_irq_pending_flag;
  logic o_broadcast_match, o_irq, o_scl_hold_oe, o_sda_ack_oe;
  wire logic i_scl_clk, i_start, i_stop, m_sda, i_sda, i_scl_rst_n;
  int n_mismatch = 0, total_checks = 0;
  assign i_sda = m_sda & ~o_sda_ack_oe;
  assign i_scl_rst_n = i_rst_n;
  i2c_addressing_gencall_irq dut (.*);
  i2c_bus_master_model bm (.i_hold(o_scl_hold_oe), .i_sda_line(i_sda), .o_scl(i_scl_clk),
    .o_sda(m_sda),
    .o_start(i_start), .o_stop(i_stop));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(bit s, logic [7:0] b);
    bm.send(s, b);
    cyc(8);
  endtask
  // Software service: clear pending, write control, read data
  task automatic clear_all();
    {i_irq_clear, i_ctrl_write, i_data_read} = 3'h7;
    cyc(1);
    {i_irq_clear, i_ctrl_write, i_data_read} = 3'h0;
    cyc(2);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    logic [7:0] bad [5] = '{8'h56, 8'h04, 8'h07, 8'hF8, 8'hF4};
    cyc(3);
    i_rst_n = 1;
    cyc(3);
    chk("aas", o_addressed_as_slave_flag, 0); chk("irq", o_irq, 0);
    i_addr_len_sel = 0;
    i_own_addr_reg = 7'h2A;
    i_iface_enable = 1;
    i_irq_enable = 1;
    xfer(1, 8'h54);
    chk("ack", bm.acked, 1);
    chk("aas", o_addressed_as_slave_flag, 1); chk("done", o_xfer_done_flag, 1);
    chk("data", o_xfer_data_reg, 8'h54); chk("bcast", o_broadcast_match, 0);
    chk("irq", o_irq, 1); chk("hold", o_scl_hold_oe, 1);
    clear_all();
    chk("pend", o_irq_pending_flag, 0); chk("irq", o_irq, 0);
    chk("aas", o_addressed_as_slave_flag, 0); chk("done", o_xfer_done_flag, 0);
    chk("hold", o_scl_hold_oe, 0);
    i_broadcast_accept_en = 1;
    foreach (bad[i]) begin
      xfer(1, bad[i]);
      chk("aas", o_addressed_as_slave_flag, 0);
      chk("ack", bm.acked, 0);
    end
    xfer(1, 8'h00);
    chk("ack", bm.acked, 1);
    chk("aas", o_addressed_as_slave_flag, 1); chk("bcast", o_broadcast_match, 1);
    chk("data", o_xfer_data_reg, 8'h00);
    clear_all();
    xfer(0, 8'hA5);
    chk("ack", bm.acked, 1);
    chk("data", o_xfer_data_reg, 8'hA5); chk("done", o_xfer_done_flag, 1);
    clear_all();
    bm.stop();
    i_broadcast_accept_en = 0;
    xfer(1, 8'h00);
    chk("aas", o_addressed_as_slave_flag, 0);
    chk("ack", bm.acked, 0);
    i_iface_enable = 0;
    i_addr_len_sel = 1;
    i_own_addr_upper = 3'h5;
    i_own_addr_reg = 7'h45;
    i_iface_enable = 1;
    xfer(1, 8'hF4);
    chk("ack10", bm.acked, 1);
    xfer(0, 8'hC5);
    chk("aas10", o_addressed_as_slave_flag, 1);
    clear_all();
    xfer(1, 8'hF5);
    chk("aas10r", o_addressed_as_slave_flag, 1);
    clear_all();
    bm.stop();
    i_own_addr_upper = 3'h1;
    xfer(1, 8'hF4);
    xfer(0, 8'hC5);
    chk("aas10", o_addressed_as_slave_flag, 0);
    bm.stop();
    {i_addr_len_sel, i_own_addr_reg, i_wait_mode, i_wait_gate_cfg} = {1'h0, 7'h2A, 2'h3};
    xfer(1, 8'h54);
    chk("aasw", o_addressed_as_slave_flag, 0);
    chk("ackw", bm.acked, 0);
    i_wait_gate_cfg = 0;
    xfer(1, 8'h54);
    chk("aasw", o_addressed_as_slave_flag, 1);
    clear_all();
    i_wait_mode = 0;
    i_irq_enable = 0;
    i_arb_lost_event = 1;
    cyc(1);
    i_arb_lost_event = 0;
    cyc(3);
    chk("arb", o_arb_lost_flag, 1); chk("irq", o_irq, 0);
    i_irq_enable = 1;
    cyc(2);
    chk("irq", o_irq, 1);
    i_stop_mode = 1;
    cyc(1);
    xfer(1, 8'h54);
    chk("aass", o_addressed_as_slave_flag, 0); chk("arb", o_arb_lost_flag, 1);
    chk("acks", bm.acked, 0);
    chk("stall", bm.stuck, 0);
    results();
  end
endmodule
`default_nettype wire
